//--- ccc_divider.sv
// Power-of-two divider chain with stop-at-low and bypass
`timescale 1ns/1ps
module ccc_divider
  import ccc_pkg::*;
#(
  parameter int STAGES = DIV_STAGES
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Control
  input  wire logic                 in_tick,
  input  wire logic                 enable,
  input  wire logic                 bypass,
  input  wire logic [DIV_SEL_W-1:0] sel,
  // Output
  output logic                      div_out
);
  logic [STAGES-1:0] cnt_reg;
  logic              run_reg;
  logic              out_reg;
  logic              byp_level_reg;
  wire               tap = cnt_reg[sel];

  // The four-bit tap select reaches exactly sixteen stages
  if (STAGES != 16) begin : g_bad_stages
    $error("divider needs 16 stages");
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
    end else if (enable) begin
      run_reg <= 1'b1;
    end else if (!tap) begin
      run_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if ((run_reg || enable) && in_tick) begin
      cnt_reg <= cnt_reg + STAGES'(1);
    end
  end
  // Bypass level toggles each input tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_level_reg <= 1'b0;
    end else if (in_tick) begin
      byp_level_reg <= ~byp_level_reg;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= bypass ? byp_level_reg : (run_reg & tap);
    end
  end
  assign div_out = out_reg;
endmodule

//--- ccc_pkg.sv
// Package: register map, field positions and encodings of the clock controller
package ccc_pkg;
  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] PWR_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CLK_SEL0_OFS   = 8'h04;
  localparam logic [7:0] DIVIDER_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0c;
  // Power control fields
  localparam int PD_EN_BIT      = 7;
  localparam int PD_WAIT_BIT    = 8;
  localparam int PLL_REF_BIT    = 0;
  localparam int WDT_SRC_BIT    = 1;
  localparam int TMR_SRC_BIT    = 2;
  localparam int TICK_EXT_BIT   = 3;
  // Clock select 0 fields
  localparam int SYS_SEL_LSB    = 0;
  localparam int TICK_SEL_LSB   = 3;
  localparam int SEL_W          = 3;
  // Divider fields
  localparam int DIV_SEL_LSB    = 0;
  localparam int DIV_SEL_W      = 4;
  localparam int DIV_EN_BIT     = 4;
  localparam int DIV_BYP_BIT    = 5;
  // Reset values
  localparam logic [8:0] PWR_CTRL_RST = 9'h000;
  localparam logic [5:0] CLK_SEL0_RST = 6'h00;
  localparam logic [5:0] DIVIDER_RST  = 6'h00;
  // Source encodings
  localparam logic [2:0] SRC_XTAL  = 3'h0;
  localparam logic [2:0] SRC_PLL   = 3'h2;
  localparam logic [2:0] SRC_SLOW  = 3'h3;
  localparam logic [2:0] SRC_FAST  = 3'h7;
  // Divider depth
  localparam int DIV_STAGES = 16;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT_WFI, ST_DOWN} ccc_pm_state_t;
endpackage

//--- ccc_src_mux.sv
// Source selector: picks one of four clock-source enables by code
`timescale 1ns/1ps
module ccc_src_mux
  import ccc_pkg::*;
(
  // Select code
  input  wire logic [2:0] sel,
  // Source ticks
  input  wire logic       xtal_tick,
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  input  wire logic       pll_tick,
  // Selected tick
  output logic            out_tick
);
  // Decode; unknown codes fall back to the fast RC
  assign out_tick = (sel == SRC_XTAL) ? xtal_tick :
                    (sel == SRC_PLL)  ? pll_tick  :
                    (sel == SRC_SLOW) ? slow_tick : fast_tick;
endmodule

//--- ccc_top.sv
// Clock controller top: registers, source select, power-down sequencing
//
// Overview of operation
// - WAIT_FOR_INTERRUPT_INSTRUCTION enters power-down when both bits set
// - Stay powered down until wake-up interrupt
// - Power-down stops crystal and fast RC
// - Four sources; PLL reference crystal or RC
// - System source chosen by select bits 2:0
// - Tick: processor clock or source bits 5:3
// - Slow RC stays on; WDT/timer if slow
// - Sixteen halving stages, one tap to pin
// - Output equals input over 2^(N+1)
// - Enable bit one starts divider counting
// - Enable zero stops only at low level
// - Bypass bit feeds pin a level toggled by each input tick
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [31:0]     rdata,
  // Source ticks
  input  wire logic       xtal_tick,
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  input  wire logic       pll_tick,
  // Processor events
  input  wire logic       wait_for_interrupt_instruction,
  input  wire logic       wake_irq,
  // Clock enables out
  output logic            xtal_en,
  output logic            fast_rc_en,
  output logic            slow_rc_en,
  output logic            pll_ref_sel,
  output logic            sys_clk_en,
  output logic            sys_tick,
  output logic            tick_clk,
  output logic            wdt_clk_en,
  output logic            tmr_clk_en,
  output logic            power_down,
  // Divider pin
  output logic            clock_output_pin
);
  logic [8:0]     pwr_reg;
  logic [5:0]     sel0_reg;
  logic [5:0]     div_reg;
  logic [31:0]    rdata_reg;
  ccc_pm_state_t  st_reg, st_next;
  logic           sys_sel_tick;
  logic           tick_sel_tick;
  logic           sys_tick_reg;
  logic           tick_reg;
  logic           xtal_en_reg, fast_en_reg, sys_en_reg;
  logic           wdt_en_reg, tmr_en_reg, pll_ref_reg;
  logic           slow_en_reg, pd_reg;
  logic           div_pin;

  // Write decodes
  wire wr_pwr  = wr && (addr == PWR_CTRL_OFS);
  wire wr_sel0 = wr && (addr == CLK_SEL0_OFS);
  wire wr_div  = wr && (addr == DIVIDER_OFS);
  wire pd_armed = pwr_reg[PD_EN_BIT] && pwr_reg[PD_WAIT_BIT];
  wire in_down  = (st_reg == ST_DOWN);

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    (addr == PWR_CTRL_OFS) ? {23'h00_0000, pwr_reg} :
    (addr == CLK_SEL0_OFS) ? {26'h000_0000, sel0_reg} :
    (addr == DIVIDER_OFS)  ? {26'h000_0000, div_reg} :
    (addr == STATUS_OFS)   ? {30'h0000_0000, st_reg} : 32'h0000_0000;

  // Software registers
  // divider bits cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg  <= PWR_CTRL_RST;
      sel0_reg <= CLK_SEL0_RST;
      div_reg  <= DIVIDER_RST;
    end else begin
      if (wr_pwr)  pwr_reg  <= wdata[8:0];
      if (wr_sel0) sel0_reg <= wdata[5:0];
      if (wr_div)  div_reg  <= wdata[5:0];
    end
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Power-down sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN:      if (wait_for_interrupt_instruction && pd_armed) st_next = ST_DOWN;
      ST_WAIT_WFI: st_next = ST_RUN;
      ST_DOWN:     if (wake_irq) st_next = ST_RUN;
      default:     st_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RUN;
      pd_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      // Pin copy of the down state, same edge as the state
      pd_reg <= (st_next == ST_DOWN);
    end
  end

  ccc_src_mux u_sys_mux (
    .sel       (sel0_reg[SYS_SEL_LSB +: SEL_W]),
    .xtal_tick (xtal_tick),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick),
    .pll_tick  (pll_tick),
    .out_tick  (sys_sel_tick)
  );

  ccc_src_mux u_tick_mux (
    .sel       (sel0_reg[TICK_SEL_LSB +: SEL_W]),
    .xtal_tick (xtal_tick),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick),
    .pll_tick  (pll_tick),
    .out_tick  (tick_sel_tick)
  );

  // Gated clocks and oscillator enables, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_tick_reg <= 1'b0;
      tick_reg     <= 1'b0;
      xtal_en_reg  <= 1'b1;
      fast_en_reg  <= 1'b1;
      sys_en_reg   <= 1'b1;
      wdt_en_reg   <= 1'b1;
      tmr_en_reg   <= 1'b1;
      pll_ref_reg  <= 1'b0;
      slow_en_reg  <= 1'b1;
    end else begin
      sys_en_reg   <= ~in_down;
      sys_tick_reg <= sys_sel_tick & ~in_down;
      tick_reg     <= (pwr_reg[TICK_EXT_BIT] ? tick_sel_tick : sys_sel_tick)
                      & ~in_down;
      xtal_en_reg  <= ~in_down;
      fast_en_reg  <= ~in_down;
      wdt_en_reg   <= ~in_down | pwr_reg[WDT_SRC_BIT];
      tmr_en_reg   <= ~in_down | pwr_reg[TMR_SRC_BIT];
      pll_ref_reg  <= pwr_reg[PLL_REF_BIT];
      slow_en_reg  <= 1'b1;
    end
  end

  ccc_divider #(.STAGES(DIV_STAGES)) u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .in_tick (sys_sel_tick),
    .enable  (div_reg[DIV_EN_BIT]),
    .bypass  (div_reg[DIV_BYP_BIT]),
    .sel     (div_reg[DIV_SEL_LSB +: DIV_SEL_W]),
    .div_out (div_pin)
  );

  // Outputs
  assign rdata            = rdata_reg;
  assign xtal_en          = xtal_en_reg;
  assign fast_rc_en       = fast_en_reg;
  assign slow_rc_en       = slow_en_reg;
  assign pll_ref_sel      = pll_ref_reg;
  assign sys_clk_en       = sys_en_reg;
  assign sys_tick         = sys_tick_reg;
  assign tick_clk         = tick_reg;
  assign wdt_clk_en       = wdt_en_reg;
  assign tmr_clk_en       = tmr_en_reg;
  assign power_down       = pd_reg;
  assign clock_output_pin = div_pin;
endmodule

//--- ccc_top_sva.sv
// Port-level assertions of the clock controller
`timescale 1ns/1ps
module ccc_top_sva
  import ccc_pkg::*;
(
  // Clock and reset
  input logic        clk,
  input logic        rst_n,
  // Register writes
  input logic [7:0]  addr,
  input logic [31:0] wdata,
  input logic        wr,
  // Sources and processor events
  input logic        xtal_tick,
  input logic        fast_tick,
  input logic        slow_tick,
  input logic        pll_tick,
  input logic        wait_for_interrupt_instruction,
  input logic        wake_irq,
  // Watched outputs
  input logic        xtal_en,
  input logic        fast_rc_en,
  input logic        slow_rc_en,
  input logic        sys_tick,
  input logic        tmr_clk_en,
  input logic        power_down,
  input logic        clock_output_pin
);
  logic [8:0] pw_reg;
  logic [5:0] cs_reg;
  logic [5:0] dv_reg;
  wire        tk;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // System source tick as the select code should pick it
  assign tk = cs_reg[2:0] == SRC_XTAL ? xtal_tick :
              cs_reg[2:0] == SRC_PLL  ? pll_tick :
              cs_reg[2:0] == SRC_SLOW ? slow_tick : fast_tick;
  // Shadow of the writable registers, rebuilt from the port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_reg <= PWR_CTRL_RST;
      cs_reg <= CLK_SEL0_RST;
      dv_reg <= DIVIDER_RST;
    end else if (wr) begin
      if (addr == PWR_CTRL_OFS) pw_reg <= wdata[8:0];
      if (addr == CLK_SEL0_OFS) cs_reg <= wdata[5:0];
      if (addr == DIVIDER_OFS) dv_reg <= wdata[5:0];
    end
  end
  // Power-down entry, refusal, hold and wake
  property p_pd_in;
    !power_down && wait_for_interrupt_instruction && &pw_reg[8:7] |=> power_down; endproperty
  property p_pd_no;
    !power_down && !(wait_for_interrupt_instruction && &pw_reg[8:7]) |=> !power_down; endproperty
  property p_pd_hold;
    power_down && !wake_irq |=> power_down; endproperty
  property p_wake;
    power_down && wake_irq |=> !power_down; endproperty
  // Fast oscillators follow power-down one cycle late
  property p_osc;
    1 |=> xtal_en == !$past(power_down) && fast_rc_en == xtal_en;
  endproperty
  property p_slow;
    power_down ##1 power_down && !pw_reg[TMR_SRC_BIT]
      |-> slow_rc_en && !tmr_clk_en; endproperty
  property p_sys;
    !power_down ##1 !power_down |-> sys_tick == $past(tk); endproperty
  // Disabled divider parks low once it falls
  property p_stop;
    $fell(clock_output_pin) && dv_reg[5:4] == 2'b00 && $stable(dv_reg)
      |=> !clock_output_pin [*3]; endproperty
  // Tick toggles the level, the pin takes it one edge later
  property p_byp;
    dv_reg[5] && !power_down && tk ##1 dv_reg[5]
      |=> $changed(clock_output_pin);
  endproperty
  a_pd_in: assert property (p_pd_in) else $error("no power-down");
  a_pd_no: assert property (p_pd_no) else $error("early power-down");
  a_pd_hold: assert property (p_pd_hold) else $error("left early");
  a_wake: assert property (p_wake) else $error("no wake");
  a_osc: assert property (p_osc) else $error("fast osc state");
  a_slow: assert property (p_slow) else $error("slow clocks");
  a_sys: assert property (p_sys) else $error("system tick");
  a_stop: assert property (p_stop) else $error("not parked low");
  a_byp: assert property (p_byp) else $error("bypass idle");
  // Main scenarios reached
  c_pd: cover property (power_down ##1 !power_down);
  c_byp: cover property (dv_reg[5] && tk);
  c_div: cover property (dv_reg[4] && $rose(clock_output_pin));
endmodule

//--- ccc_top_tb.sv
// Self-checking bench of the clock controller top
`timescale 1ns/1ps
bind ccc_top ccc_top_sva chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .xtal_tick(xtal_tick), .fast_tick(fast_tick),
  .slow_tick(slow_tick), .pll_tick(pll_tick), .wait_for_interrupt_instruction(wait_for_interrupt_instruction),
  .wake_irq(wake_irq), .xtal_en(xtal_en), .fast_rc_en(fast_rc_en),
  .slow_rc_en(slow_rc_en), .sys_tick(sys_tick), .tmr_clk_en(tmr_clk_en),
  .power_down(power_down), .clock_output_pin(clock_output_pin));
module ccc_top_tb
  import ccc_pkg::*;
;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, wait_for_interrupt_instruction = 0, wake_irq = 0;
  logic        xtal_tick = 0, fast_tick = 0, slow_tick = 0, pll_tick = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic        xtal_en, fast_rc_en, slow_rc_en, pll_ref_sel, sys_clk_en;
  logic        sys_tick, tick_clk, wdt_clk_en, tmr_clk_en, power_down;
  logic        clock_output_pin;
  int          failures = 0;
  int          tests_run = 0;
  int          seed = 32'hf183_b39e;
  ccc_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .xtal_tick(xtal_tick),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .pll_tick(pll_tick),
    .wait_for_interrupt_instruction(wait_for_interrupt_instruction), .wake_irq(wake_irq), .xtal_en(xtal_en),
    .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en),
    .pll_ref_sel(pll_ref_sel), .sys_clk_en(sys_clk_en),
    .sys_tick(sys_tick), .tick_clk(tick_clk), .wdt_clk_en(wdt_clk_en),
    .tmr_clk_en(tmr_clk_en), .power_down(power_down),
    .clock_output_pin(clock_output_pin));
  // 40 MHz clock and random source ticks
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    {xtal_tick, fast_tick, slow_tick, pll_tick} <= 4'($random(seed));
  end
  task wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task give_up();
    failures++;
    wrap_up();
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Register port cycles, one strobe cycle each
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // One-cycle pulse of wfi or of the wake request
  task pulse(input logic w);
    @(posedge clk);
    wait_for_interrupt_instruction <= w;
    wake_irq <= !w;
    @(posedge clk);
    wait_for_interrupt_instruction <= 1'b0;
    wake_irq <= 1'b0;
    #1;
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] a,
                                         input logic [31:0] d);
    case (a)
      PWR_CTRL_OFS: return d & 32'h0000_01ff;
      CLK_SEL0_OFS, DIVIDER_OFS: return d & 32'h0000_003f;
      default: return 32'h0000_0000;
    endcase
  endfunction
  // Ticks between rises; first two rises skipped as the count settles
  task automatic per(input int n);
    int   t = 0;
    int   t0 = 0;
    int   k = 0;
    logic lp = 1'b1;
    logic [1:0] tp = 2'b00;
    for (int i = 0; i < 4000 && k < 4; i++) begin
      @(posedge clk);
      // Pin rises two edges after the tick that steps the count, so ticks lag by two
      if (tp[1]) t++;
      tp = {tp[0], xtal_tick};
      if (clock_output_pin && !lp) begin
        if (k > 1) chk(32'(t - t0), 32'(1 << (n + 1)));
        t0 = t;
        k++;
      end
      lp = clock_output_pin;
    end
    if (k < 4) give_up();
  endtask
  // Main sequence
  initial begin
    logic [7:0]  a;
    logic [31:0] d;
    int          nl[3] = '{0, 1, 3};
    logic [2:0]  hb;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(clock_output_pin, 1'b0);
    rreg(DIVIDER_OFS, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      a = (i == 7) ? 8'h40 : 8'(($random(seed) & 3) * 4);
      wreg(a, d);
      rreg(a, exp_rd(a, d));
    end
    wreg(CLK_SEL0_OFS, 32'(SRC_XTAL));
    wreg(PWR_CTRL_OFS, 32'h0000_0000);
    foreach (nl[k]) begin
      wreg(DIVIDER_OFS, 32'h0000_0010 | nl[k]);
      per(nl[k]);
    end
    wreg(DIVIDER_OFS, 32'h0000_0003);
    // Enable drop is seen two edges on; then the first low parks it
    repeat (2) @(posedge clk);
    for (int i = 0; i < 200 && clock_output_pin; i++) @(posedge clk);
    if (clock_output_pin) give_up();
    repeat (20) begin
      @(posedge clk);
      chk(clock_output_pin, 1'b0);
    end
    wreg(DIVIDER_OFS, 32'h0000_0020);
    // Pin flips exactly when a tick came two edges earlier
    for (int i = 0; i < 42; i++) begin
      @(posedge clk);
      if (i >= 2) chk(clock_output_pin ^ hb[0], hb[2]);
      hb = {hb[1], xtal_tick, clock_output_pin};
    end
    wreg(DIVIDER_OFS, 32'h0000_0000);
    wreg(PWR_CTRL_OFS, 32'h0000_0080);
    pulse(1'b1);
    chk(power_down, 1'b0);
    wreg(PWR_CTRL_OFS, 32'h0000_0183);
    pulse(1'b1);
    chk(power_down, 1'b1);
    @(posedge clk);
    #1;
    chk({xtal_en, fast_rc_en, slow_rc_en}, 3'b001);
    chk({wdt_clk_en, tmr_clk_en, sys_clk_en, tick_clk}, 4'b1000);
    chk(pll_ref_sel, 1'b1);
    rreg(STATUS_OFS, 32'(ST_DOWN));
    pulse(1'b0);
    chk(power_down, 1'b0);
    @(posedge clk);
    #1;
    chk(xtal_en, 1'b1);
    // Tick from the external path, PLL code, one edge late
    wreg(CLK_SEL0_OFS, 32'h0000_0010);
    wreg(PWR_CTRL_OFS, 32'h0000_0008);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (i > 0) chk({tick_clk, sys_clk_en}, {hb[1], 1'b1});
      hb[1] = pll_tick;
    end
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    give_up();
  end
endmodule
